/* File: logic/ssc_dev_end.sv */
// drive slave end: byte fifo, frame check and command word decode
// Functional notes
// - character check negates byte sum modulo 256
// - binary check register presets to all ones
// - each byte xors into low check byte
// - shift right, fold polynomial on dropped one
// - eight shifts complete each byte
// - final register value is frame check
// - check low byte sent before high byte
// - parameter address: high group, low number
// - master reads one parameter per request
// - command bits 1:0 stop, run, jog run
// - command bits 5:4 forward, reverse, toggle
// - command bits 7:6 pick accel set
// - step speed bits; bit 12 enables them
// - aux word: fault bit 0, reset bit 1

`include "ssc_regs.svh"

// ----------------------------------------------------------------------------
// byte fifo
// ----------------------------------------------------------------------------
module ssc_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         mclk,      // system clock
  input  wire logic         rst,       // async reset, high
  input  wire logic         in_valid,  // write side offers
  output logic              in_ready,  // room left
  input  wire logic [W-1:0] in_data,   // write word
  output logic              out_valid, // word waiting
  input  wire logic         out_ready, // reader takes
  output logic      [W-1:0] out_data   // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_r];

  // storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop)  rp_r <= rp_r + AW'(1);
      if (push && !pop) cnt_r <= cnt_r + (AW+1)'(1);
      else if (pop && !push) cnt_r <= cnt_r - (AW+1)'(1);
    end
  end
endmodule

// ----------------------------------------------------------------------------
// slave end
// ----------------------------------------------------------------------------
module ssc_dev_end (
  input  wire logic   mclk,                        // 20 MHz system clock
  input  wire logic   rst,                         // async reset, high
  ssc_link_if.dev     lnk,                         // link to controller
  output logic        drive_run,                   // run level
  output logic        jog_run,                     // jog level
  output logic        stop_req,                    // stop pulse
  output logic        forward_rotation,            // forward selected
  output logic        backward_rotation,           // reverse selected
  output logic [1:0]  accel_set,                   // accel/decel set 0..3
  output logic [3:0]  step_speed,                  // step speed 0..15
  output logic        step_apply,                  // comm speed/accel in use
  output logic [15:0] freq_cmd,                    // frequency command
  output logic        outside_fault_flag,          // external fault
  output logic        fault_reset,                 // fault reset pulse
  output logic [15:0] group_number_param_address,  // last parameter address
  output logic [7:0]  param_group,                 // parameter group
  output logic [7:0]  param_number,                // parameter number
  output logic [15:0] param_data,                  // parameter write data
  output logic        param_wr,                    // parameter write pulse
  output logic        param_rd                     // parameter read pulse
);
  ssc_pkg::ssc_dev_state_type state_r;
  logic [8:0]  f_data;
  logic        f_valid;
  logic        f_ready;
  logic        take;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [7:0]  lrc_r;
  logic [2:0]  bit_r;
  logic [3:0]  idx_r;
  logic        last_r;
  logic        char_r;
  logic [7:0]  stn_r;
  logic [7:0]  fn_r;
  logic [15:0] reg_r;
  logic [15:0] dat_r;
  logic        fin;
  logic        chk_ok;
  logic        fn_ok;
  logic        good;
  logic        wr_ok;
  logic        resp_v_r;
  logic        resp_ok_r;

  ssc_fifo #(.W(`SSC_FIFO_WIDTH), .D(`SSC_FIFO_DEPTH)) u_ssc_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (lnk.byte_valid),
    .in_ready  (lnk.byte_ready),
    .in_data   ({lnk.byte_last, lnk.byte_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // drain one byte, then spend eight cycles shifting it
  assign f_ready = (state_r == ssc_pkg::DEV_TAKE);
  assign take    = f_valid && f_ready;
  assign crc_nxt = ssc_pkg::ssc_crc_shift(crc_r);

  // frame verdict; both checks include the sent check bytes, so they leave a zero residue
  assign fin    = (state_r == ssc_pkg::DEV_SHIFT) && (bit_r == `SSC_SHIFTS_LAST) && last_r;
  assign chk_ok = char_r ? (lrc_r == `SSC_LRC_RESIDUE)
                         : (crc_nxt == `SSC_CRC_RESIDUE);
  assign fn_ok  = (fn_r == `SSC_FN_WRITE) ||
                  ((fn_r == `SSC_FN_READ) && (dat_r == `SSC_READ_COUNT));
  assign good   = fin && chk_ok && fn_ok && (stn_r == `SSC_STATION) &&
                  (idx_r == (char_r ? `SSC_LEN_CHAR : `SSC_LEN_BIN));
  assign wr_ok  = good && (fn_r == `SSC_FN_WRITE);

  // sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ssc_pkg::DEV_TAKE;
      bit_r   <= 3'h0;
    end else begin
      unique case (state_r)
        ssc_pkg::DEV_TAKE: begin
          bit_r <= 3'h0;
          if (take) state_r <= ssc_pkg::DEV_SHIFT;
        end
        ssc_pkg::DEV_SHIFT: begin
          bit_r <= bit_r + 3'h1;
          if (bit_r == `SSC_SHIFTS_LAST) state_r <= ssc_pkg::DEV_TAKE;
        end
      endcase
    end
  end

  // check registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_r <= `SSC_CRC_PRESET;
      lrc_r <= 8'h00;
    end else if (take) begin
      crc_r <= (idx_r == 4'h0 ? `SSC_CRC_PRESET : crc_r)
               ^ {8'h00, f_data[7:0]};
      lrc_r <= (idx_r == 4'h0 ? 8'h00 : lrc_r) + f_data[7:0];
    end else if (state_r == ssc_pkg::DEV_SHIFT) begin
      crc_r <= crc_nxt;
    end
  end

  // frame fields by byte position
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idx_r  <= 4'h0;
      last_r <= 1'b0;
      char_r <= 1'b0;
      stn_r  <= 8'h00;
      fn_r   <= 8'h00;
      reg_r  <= 16'h0000;
      dat_r  <= 16'h0000;
    end else if (take) begin
      last_r <= f_data[8];
      idx_r  <= (idx_r == 4'hf) ? idx_r : idx_r + 4'h1;
      if (idx_r == 4'h0) char_r <= lnk.char_mode;
      unique case (idx_r)
        4'h0: stn_r        <= f_data[7:0];
        4'h1: fn_r         <= f_data[7:0];
        4'h2: reg_r[15:8]  <= f_data[7:0];
        4'h3: reg_r[7:0]   <= f_data[7:0];
        4'h4: dat_r[15:8]  <= f_data[7:0];
        4'h5: dat_r[7:0]   <= f_data[7:0];
        default: ;
      endcase
    end else if (fin) begin
      idx_r <= 4'h0;
    end
  end

  // verdict back to controller
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_v_r  <= 1'b0;
      resp_ok_r <= 1'b0;
    end else begin
      resp_v_r  <= fin;
      resp_ok_r <= good;
    end
  end
  assign lnk.resp_valid = resp_v_r;
  assign lnk.resp_ok    = resp_ok_r;

  // command word decode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_run        <= 1'b0;
      jog_run          <= 1'b0;
      stop_req         <= 1'b0;
      forward_rotation <= 1'b1;
      accel_set        <= 2'h0;
      step_speed       <= 4'h0;
      step_apply       <= 1'b0;
    end else begin
      stop_req <= 1'b0;
      if (wr_ok && reg_r == `SSC_DRIVE_COMMAND_WORD) begin
        unique case (dat_r[`SSC_CMD_RUN_LSB +: 2])
          2'h1: begin
            drive_run <= 1'b0;
            jog_run   <= 1'b0;
            stop_req  <= 1'b1;
          end
          2'h2: begin
            drive_run <= 1'b1;
            jog_run   <= 1'b0;
          end
          2'h3: begin
            drive_run <= 1'b1;
            jog_run   <= 1'b1;
          end
          default: ;
        endcase
        unique case (dat_r[`SSC_CMD_DIR_LSB +: 2])
          2'h1: forward_rotation <= 1'b1;
          2'h2: forward_rotation <= 1'b0;
          2'h3: forward_rotation <= !forward_rotation;
          default: ;
        endcase
        step_apply <= dat_r[`SSC_CMD_APPLY_BIT];
        if (dat_r[`SSC_CMD_APPLY_BIT]) begin
          accel_set  <= dat_r[`SSC_CMD_ACC_LSB +: 2];
          step_speed <= dat_r[`SSC_CMD_STEP_LSB +: 4];
        end
        // bits 3:2 and 15:13 are never looked at
      end
    end
  end
  assign backward_rotation = !forward_rotation;

  // frequency and auxiliary words
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      freq_cmd           <= 16'h0000;
      outside_fault_flag <= 1'b0;
      fault_reset        <= 1'b0;
    end else begin
      fault_reset <= 1'b0;
      if (wr_ok && reg_r == `SSC_FREQUENCY_COMMAND) freq_cmd <= dat_r;
      if (wr_ok && reg_r == `SSC_FAULT_AND_RESET_CONTROL) begin
        outside_fault_flag <= dat_r[`SSC_AUX_FAULT_BIT];
        fault_reset        <= dat_r[`SSC_AUX_RESET_BIT];
        if (dat_r[`SSC_AUX_RESET_BIT]) outside_fault_flag <= 1'b0;
      end
    end
  end

  // parameter access by group and number
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      group_number_param_address <= 16'h0000;
      param_group                <= 8'h00;
      param_number               <= 8'h00;
      param_data                 <= 16'h0000;
      param_wr                   <= 1'b0;
      param_rd                   <= 1'b0;
    end else begin
      param_wr <= 1'b0;
      param_rd <= 1'b0;
      if (good && reg_r < `SSC_PARAM_LIMIT) begin
        group_number_param_address <= reg_r;
        param_group                <= reg_r[15:8];
        param_number               <= reg_r[7:0];
        param_wr                   <= (fn_r == `SSC_FN_WRITE);
        param_rd                   <= (fn_r == `SSC_FN_READ);
        if (fn_r == `SSC_FN_WRITE) param_data <= dat_r;
      end
    end
  end
endmodule

/* File: logic/ssc_host_end.sv */
// bus master controller end: builds request frames with their check bytes
`include "ssc_regs.svh"

module ssc_host_end (
  input  wire logic        mclk,   // 20 MHz system clock
  input  wire logic        rst,    // async reset, high
  ssc_link_if.host         lnk,    // link to drive
  input  wire logic [3:0]  addr,   // register address
  input  wire logic [15:0] wdata,  // write data
  input  wire logic        wr,     // write strobe
  input  wire logic        rd,     // read strobe
  output logic      [15:0] rdata   // read data, cycle after rd
);
  ssc_pkg::ssc_host_state_type state_r;
  logic        char_r;
  logic        read_r;
  logic [15:0] tgt_r;
  logic [15:0] val_r;
  logic        busy_r;
  logic        done_r;
  logic        ok_r;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [7:0]  lrc_r;
  logic [2:0]  bit_r;
  logic [3:0]  idx_r;
  logic [7:0]  tx_r;
  logic        tx_last_r;
  logic        start;
  logic        acc;
  logic [3:0]  last_idx;

  assign start    = wr && (addr == `SSC_HOST_CTRL) && wdata[`SSC_CTRL_START] && !busy_r;
  assign acc      = (state_r == ssc_pkg::H_SEND) && lnk.byte_ready;
  assign crc_nxt  = ssc_pkg::ssc_crc_shift(crc_r);
  assign last_idx = char_r ? `SSC_IDX_CHECK : `SSC_IDX_CHECK + 4'h1;

  assign lnk.byte_valid = (state_r == ssc_pkg::H_SEND);
  assign lnk.byte_data  = tx_r;
  assign lnk.byte_last  = tx_last_r;
  assign lnk.char_mode  = char_r;

  // byte for a position; a read always asks for one word
  function automatic logic [7:0] pick(input logic [3:0] i, input logic [15:0] c,
                                      input logic [7:0] s);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      4'h0: b = `SSC_STATION;
      4'h1: b = read_r ? `SSC_FN_READ : `SSC_FN_WRITE;
      4'h2: b = tgt_r[15:8];
      4'h3: b = tgt_r[7:0];
      4'h4: b = read_r ? 8'(`SSC_READ_COUNT >> 8) : val_r[15:8];
      4'h5: b = read_r ? 8'(`SSC_READ_COUNT) : val_r[7:0];
      4'h6: b = char_r ? 8'h00 - s : c[7:0];
      default: b = c[15:8];
    endcase
    return b;
  endfunction

  // controller registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      char_r <= 1'b0;
      read_r <= 1'b0;
      tgt_r  <= 16'h0000;
      val_r  <= 16'h0000;
    end else if (wr && !busy_r) begin
      if (addr == `SSC_HOST_CTRL) begin
        char_r <= wdata[`SSC_CTRL_CHAR];
        read_r <= wdata[`SSC_CTRL_READ];
      end
      if (addr == `SSC_HOST_ADDR) tgt_r <= wdata;
      if (addr == `SSC_HOST_DATA) val_r <= wdata;
    end
  end

  // read port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        `SSC_HOST_CTRL:   rdata <= {13'h0, read_r, char_r, 1'b0};
        `SSC_HOST_ADDR:   rdata <= tgt_r;
        `SSC_HOST_DATA:   rdata <= val_r;
        `SSC_HOST_STATUS: rdata <= {13'h0, ok_r, done_r, busy_r};
        default:          rdata <= 16'h0000;
      endcase
    end
  end

  // frame sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r   <= ssc_pkg::H_IDLE;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      ok_r      <= 1'b0;
      idx_r     <= 4'h0;
      bit_r     <= 3'h0;
      tx_r      <= 8'h00;
      tx_last_r <= 1'b0;
    end else begin
      unique case (state_r)
        ssc_pkg::H_IDLE: begin
          if (start) begin
            state_r   <= ssc_pkg::H_SEND;
            busy_r    <= 1'b1;
            done_r    <= 1'b0;
            ok_r      <= 1'b0;
            idx_r     <= 4'h0;
            tx_r      <= `SSC_STATION;
            tx_last_r <= 1'b0;
          end
        end
        ssc_pkg::H_SEND: begin
          if (acc) begin
            idx_r <= idx_r + 4'h1;
            bit_r <= 3'h0;
            if (idx_r < `SSC_IDX_CHECK) begin
              state_r <= ssc_pkg::H_SHIFT;
            end else if (tx_last_r) begin
              state_r <= ssc_pkg::H_WAIT;
            end else begin
              tx_r      <= pick(idx_r + 4'h1, crc_r, lrc_r);
              tx_last_r <= 1'b1;
            end
          end
        end
        ssc_pkg::H_SHIFT: begin
          bit_r <= bit_r + 3'h1;
          if (bit_r == `SSC_SHIFTS_LAST) begin
            state_r   <= ssc_pkg::H_SEND;
            tx_r      <= pick(idx_r, crc_nxt, lrc_r);
            tx_last_r <= (idx_r == last_idx);
          end
        end
        ssc_pkg::H_WAIT: begin
          if (lnk.resp_valid) begin
            state_r <= ssc_pkg::H_IDLE;
            busy_r  <= 1'b0;
            done_r  <= 1'b1;
            ok_r    <= lnk.resp_ok;
          end
        end
      endcase
    end
  end

  // check registers folded over the six message bytes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_r <= `SSC_CRC_PRESET;
      lrc_r <= 8'h00;
    end else if (start) begin
      crc_r <= `SSC_CRC_PRESET;
      lrc_r <= 8'h00;
    end else if (acc && idx_r < `SSC_IDX_CHECK) begin
      crc_r <= crc_r ^ {8'h00, tx_r};
      lrc_r <= lrc_r + tx_r;
    end else if (state_r == ssc_pkg::H_SHIFT) begin
      crc_r <= crc_nxt;
    end
  end
endmodule

/* File: logic/ssc_link_if.sv */
// byte link between the bus master controller and the drive slave
interface ssc_link_if;
  logic       byte_valid; // controller offers a frame byte
  logic       byte_ready; // device takes the byte
  logic [7:0] byte_data;  // frame byte
  logic       byte_last;  // byte closes the frame
  logic       char_mode;  // 1: character mode, longitudinal check
  logic       resp_valid; // device verdict pulse
  logic       resp_ok;    // frame accepted

  modport dev  (input byte_valid, byte_data, byte_last, char_mode,
                output byte_ready, resp_valid, resp_ok);
  modport host (output byte_valid, byte_data, byte_last, char_mode,
                input byte_ready, resp_valid, resp_ok);
endinterface

/* File: logic/ssc_pkg.sv */
// types and shared check-register step for the serial check and decode link
`include "ssc_regs.svh"

package ssc_pkg;

  // ----------------------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------------------
  typedef enum logic [0:0] {DEV_TAKE, DEV_SHIFT} ssc_dev_state_type;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_SHIFT, H_WAIT} ssc_host_state_type;

  // one right shift of the check register, polynomial folded when a one drops out
  function automatic logic [15:0] ssc_crc_shift(input logic [15:0] c);
    logic [15:0] s;
    s = {1'b0, c[15:1]};
    if (c[0]) begin
      s = s ^ `SSC_CRC_POLY;
    end
    return s;
  endfunction

endpackage

/* File: logic/ssc_regs.svh */
// register offsets, field positions, codes and constants of the serial check and decode link
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// ----------------------------------------------------------------------------
// frame checks
// ----------------------------------------------------------------------------
`define SSC_CRC_PRESET    16'hffff
`define SSC_CRC_POLY      16'ha001
`define SSC_CRC_RESIDUE   16'h0000
`define SSC_LRC_RESIDUE   8'h00
`define SSC_SHIFTS_LAST   3'h7
`define SSC_STATION       8'h01
`define SSC_FN_READ       8'h03
`define SSC_FN_WRITE      8'h06
`define SSC_READ_COUNT    16'h0001
`define SSC_LEN_CHAR      4'h7
`define SSC_LEN_BIN       4'h8
`define SSC_IDX_CHECK     4'h6

// ----------------------------------------------------------------------------
// device word map
// ----------------------------------------------------------------------------
`define SSC_DRIVE_COMMAND_WORD      16'h2000
`define SSC_FREQUENCY_COMMAND       16'h2001
`define SSC_FAULT_AND_RESET_CONTROL 16'h2002
`define SSC_PARAM_LIMIT             16'h2000
`define SSC_CMD_RUN_LSB             0
`define SSC_CMD_DIR_LSB             4
`define SSC_CMD_ACC_LSB             6
`define SSC_CMD_STEP_LSB            8
`define SSC_CMD_APPLY_BIT           12
`define SSC_AUX_FAULT_BIT           0
`define SSC_AUX_RESET_BIT           1

// ----------------------------------------------------------------------------
// controller registers on the plain port, and byte fifo size
// ----------------------------------------------------------------------------
`define SSC_HOST_CTRL     4'h0
`define SSC_HOST_ADDR     4'h1
`define SSC_HOST_DATA     4'h2
`define SSC_HOST_STATUS   4'h3
`define SSC_CTRL_START    0
`define SSC_CTRL_CHAR     1
`define SSC_CTRL_READ     2
`define SSC_FIFO_WIDTH    9
`define SSC_FIFO_DEPTH    16

`endif

/* File: tb/serial_slave_check_and_command_decode_tb.sv */
// bench joining controller and drive ends over one link
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h seen %0h", n, e, g); end end
module serial_slave_check_and_command_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, freq_cmd, group_number_param_address, param_data, v;
  logic drive_run, jog_run, stop_req, forward_rotation, backward_rotation, step_apply;
  logic outside_fault_flag, fault_reset, param_wr, param_rd;
  logic [1:0] accel_set;
  logic [3:0] step_speed;
  logic [7:0] param_group, param_number;
  logic [31:0] seed = 32'h4957;
  int fails = 0, checks = 0, n_stop = 0, n_frst = 0, n_pwr = 0, n_prd = 0;
  int m_run, m_jog, m_fwd = 1, m_acc, m_step, m_app, m_ef, m_freq, e_stop, e_frst, e_pwr, e_prd;
  ssc_link_if lnk ();
  ssc_host_end u_ssc_host_end (.mclk(mclk), .rst(rst), .lnk(lnk.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ssc_dev_end u_ssc_dev_end (.mclk(mclk), .rst(rst), .lnk(lnk.dev), .drive_run(drive_run),
    .jog_run(jog_run), .stop_req(stop_req), .forward_rotation(forward_rotation),
    .backward_rotation(backward_rotation), .accel_set(accel_set), .step_speed(step_speed),
    .step_apply(step_apply), .freq_cmd(freq_cmd), .outside_fault_flag(outside_fault_flag),
    .fault_reset(fault_reset), .group_number_param_address(group_number_param_address),
    .param_group(param_group), .param_number(param_number), .param_data(param_data),
    .param_wr(param_wr), .param_rd(param_rd));
  ssc_link_asserts u_ssc_link_asserts (.mclk(mclk), .rst(rst), .byte_valid(lnk.byte_valid),
    .byte_ready(lnk.byte_ready), .byte_data(lnk.byte_data), .byte_last(lnk.byte_last),
    .char_mode(lnk.char_mode), .resp_valid(lnk.resp_valid), .resp_ok(lnk.resp_ok));
  always #25 mclk = ~mclk;
  // count the one-cycle pulses of the drive end
  always @(posedge mclk) begin
    n_stop += int'(stop_req === 1'b1);
    n_frst += int'(fault_reset === 1'b1);
    n_pwr += int'(param_wr === 1'b1);
    n_prd += int'(param_rd === 1'b1);
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // ----
  // one request frame, model update and comparison
  // ----
  task automatic op(input bit rdm, input bit chm, input logic [15:0] a, input logic [15:0] d);
    int n;
    wrr(4'h1, a);
    wrr(4'h2, d);
    wrr(4'h0, {13'h0, rdm, chm, 1'b1});
    n = 0;
    v = 16'h0000;
    while (v[1] !== 1'b1 && n < 300) begin
      rdr(4'h3);
      n++;
    end
    if (rdm) e_prd++;
    else if (a < 16'h2000) e_pwr++;
    else if (a == 16'h2000) begin
      if (d[1:0] != 2'b00) m_run = d[1];
      if (d[1:0] != 2'b00) m_jog = int'(d[1:0] == 2'b11);
      e_stop += int'(d[1:0] == 2'b01);
      if (d[5:4] != 2'b00) m_fwd = (d[5:4] == 2'b11) ? 1 - m_fwd : int'(d[5:4] == 2'b01);
      if (d[12]) m_acc = d[7:6];
      if (d[12]) m_step = d[11:8];
      m_app = d[12];
    end else if (a == 16'h2001) m_freq = d;
    else begin
      m_ef = d[1] ? 0 : d[0];
      e_frst += d[1];
    end
    `CHK("status", 16'h0006, v & 16'h0007)
    `CHK("run", m_run, drive_run)
    `CHK("jog", m_jog, jog_run)
    `CHK("stops", e_stop, n_stop)
    `CHK("fwd", m_fwd, forward_rotation)
    `CHK("rev", 1 - m_fwd, backward_rotation)
    `CHK("accel", m_acc, accel_set)
    `CHK("step", m_step, step_speed)
    `CHK("apply", m_app, step_apply)
    `CHK("freq", m_freq, freq_cmd)
    `CHK("fault", m_ef, outside_fault_flag)
    `CHK("resets", e_frst, n_frst)
    `CHK("pwr", e_pwr, n_pwr)
    `CHK("prd", e_prd, n_prd)
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #1000000;
    fails++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      op(1'b0, i[0], 16'h2000, {seed[15:6], i[3:2], seed[3:2], i[1:0]});
    end
    $display("test command words done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      op(1'b0, i[0], 16'h2001, seed[15:0]);
    end
    op(1'b0, 1'b0, 16'h2002, 16'hfffd);
    op(1'b0, 1'b1, 16'h2002, 16'h0002);
    op(1'b0, 1'b0, 16'h2002, 16'h0001);
    op(1'b0, 1'b1, 16'h2002, 16'hfffe);
    $display("test frequency and fault done");
    seed = xs(seed);
    op(1'b0, 1'b1, 16'h0401, seed[15:0]);
    `CHK("group", 8'h04, param_group)
    `CHK("number", 8'h01, param_number)
    `CHK("pdata", seed[15:0], param_data)
    op(1'b1, 1'b0, 16'h1fff, 16'h0000);
    `CHK("paddr", 16'h1fff, group_number_param_address)
    $display("test parameters done");
    rdr(4'h7);
    `CHK("unmapped", 16'h0000, v)
    rdr(4'h0);
    `CHK("ctrl", 16'h0004, v & 16'h0007)
    rdr(4'h1);
    `CHK("haddr", 16'h1fff, v)
    $display("test host registers done");
    give_verdict();
  end
endmodule

/* File: tb/ssc_link_asserts.sv */
// checker on the byte link between controller and drive ends
module ssc_link_asserts (
  input wire logic       mclk,       // system clock
  input wire logic       rst,        // async reset, high
  input wire logic       byte_valid, // byte offered
  input wire logic       byte_ready, // room in fifo
  input wire logic [7:0] byte_data,  // frame byte
  input wire logic       byte_last,  // byte closes frame
  input wire logic       char_mode,  // longitudinal check
  input wire logic       resp_valid, // verdict pulse
  input wire logic       resp_ok     // frame accepted
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] crc_r;
  logic [7:0]  sum_r;
  logic [3:0]  idx_r;
  logic [7:0]  fn_r;
  logic        take;
  assign take = byte_valid && byte_ready;
  // check register after folding one byte in
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? ({1'b0, r[15:1]} ^ 16'ha001) : {1'b0, r[15:1]};
    return r;
  endfunction
  // running checks over the frame in flight
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_r <= 16'hffff;
      sum_r <= 8'h00;
      idx_r <= 4'h0;
      fn_r  <= 8'h00;
    end else if (take) begin
      crc_r <= byte_last ? 16'hffff : crc8(crc_r, byte_data);
      sum_r <= byte_last ? 8'h00 : sum_r + byte_data;
      idx_r <= byte_last ? 4'h0 : idx_r + 4'h1;
      fn_r  <= (idx_r == 4'h1) ? byte_data : fn_r;
    end
  end
  // ----
  // link properties
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_lrc; take && byte_last && char_mode |-> 8'(sum_r + byte_data) == 8'h00; endproperty
  a_lrc: assert property (p_lrc) else $error("sum check wrong");
  property p_crc; take && byte_last && !char_mode |-> crc8(crc_r, byte_data) == 16'h0000;
  endproperty
  a_crc: assert property (p_crc) else $error("crc residue wrong");
  property p_lo; take && !char_mode && idx_r == 4'h6 |-> byte_data == crc_r[7:0]; endproperty
  a_lo: assert property (p_lo) else $error("crc low byte not first");
  property p_gap; take && !char_mode && idx_r < 4'h6 |=> !byte_valid [*8] ##1 byte_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("shift gap wrong");
  property p_len; take && byte_last |-> idx_r == (char_mode ? 4'h6 : 4'h7); endproperty
  a_len: assert property (p_len) else $error("frame length wrong");
  property p_one; take && fn_r == 8'h03 && idx_r[3:1] == 3'h2 |-> byte_data == {7'h00, idx_r[0]};
  endproperty
  a_one: assert property (p_one) else $error("read count not one");
  property p_resp; take && byte_last |-> ##[1:40] (resp_valid && resp_ok); endproperty
  a_resp: assert property (p_resp) else $error("no good verdict");
  property p_pulse; resp_valid |=> !resp_valid && $stable(char_mode); endproperty
  a_pulse: assert property (p_pulse) else $error("verdict too long");
endmodule
